// file: rtl/ldr_pkg.sv
// Shared constants, types and decode tables for the Direct-mode LED ramp and off-delay block.
// Assumes a byte-wide register port driven by the management bus engine on the system clock.
package ldr_pkg;

   // Number of LED channels that this block times in Direct mode
   localparam int LED_COUNT = 4;

   // Register addresses as the management bus presents them
   localparam logic [7:0] ADDR_DUTY = 8'h93;   // Direct duty cycle limits
   localparam logic [7:0] ADDR_RAMP = 8'h94;   // Direct ramp rates
   localparam logic [7:0] ADDR_DELAY = 8'h95;  // Direct off delay

   // Reset values
   localparam logic [7:0] DUTY_RESET = 8'hf0;
   localparam logic [7:0] RAMP_RESET = 8'h00;
   localparam logic [7:0] DELAY_RESET = 8'h00;

   // Writable bit masks; bits outside read as zero
   localparam logic [7:0] DUTY_MASK = 8'hff;
   localparam logic [7:0] RAMP_MASK = 8'h3f;
   localparam logic [7:0] DELAY_MASK = 8'h07;
   localparam logic [7:0] READ_IDLE = 8'h00;   // Answer to an unmapped address

   // Field positions
   localparam int CODE_W = 3;
   localparam int RISE_LSB = 3;
   localparam int FALL_LSB = 0;
   localparam int HOLD_LSB = 0;
   localparam int DUTY_W = 4;
   localparam int UPPER_LSB = 4;
   localparam int LOWER_LSB = 0;

   // Time base: one tick per millisecond at the system clock rate
   localparam int CLK_MHZ = 250;
   localparam int TICK_TIME_US = 1000;
   localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
   localparam int TICK_W = 18;

   // Ramp resolution and PWM frame: the frame spans PCT_FULL * RAMP_STEPS clocks
   localparam logic [7:0] RAMP_STEPS = 8'hfa;  // 250 steps per ramp
   localparam int PCT_FULL = 100;
   localparam int PWM_W = 15;
   localparam logic [PWM_W-1:0] PWM_LAST = PWM_W'(PCT_FULL * 250 - 1);
   localparam int HOLD_W = 13;
   localparam int STEP_W = 4;

   typedef logic [CODE_W-1:0] ldr_code_t;
   typedef logic [7:0] ldr_pos_t;
   typedef logic [15:0] ldr_cmp_t;
   typedef logic [HOLD_W-1:0] ldr_ms_t;
   typedef logic [STEP_W-1:0] ldr_step_t;

   // Ramp phase of one LED
   typedef enum logic [2:0] {PH_LOW, PH_RISE, PH_HIGH, PH_HOLD, PH_FALL} ldr_phase_t;

   // Rise or fall time in ms for a three-bit code
   function automatic logic [11:0] ramp_ms(input ldr_code_t code);
      case (code)
         3'h0: ramp_ms = 12'h000;
         3'h1: ramp_ms = 12'h0fa;
         3'h2: ramp_ms = 12'h1f4;
         3'h3: ramp_ms = 12'h2ee;
         3'h4: ramp_ms = 12'h3e8;
         3'h5: ramp_ms = 12'h4e2;
         3'h6: ramp_ms = 12'h5dc;
         default: ramp_ms = 12'h7d0;
      endcase
   endfunction

   // Milliseconds per ramp step; zero means an instant change
   function automatic ldr_step_t step_ms(input ldr_code_t code);
      step_ms = STEP_W'(ramp_ms(code) / 12'(RAMP_STEPS));
   endfunction

   // Off delay in ms for a three-bit code
   function automatic ldr_ms_t hold_ms(input ldr_code_t code);
      case (code)
         3'h0: hold_ms = 13'h0000;
         3'h1: hold_ms = 13'h01f4;
         3'h2: hold_ms = 13'h03e8;
         3'h3: hold_ms = 13'h05dc;
         3'h4: hold_ms = 13'h07d0;
         3'h5: hold_ms = 13'h0bb8;
         3'h6: hold_ms = 13'h0fa0;
         default: hold_ms = 13'h1388;
      endcase
   endfunction

   // Duty in percent; the lower limit of code n equals the upper limit of code n-1
   function automatic logic [7:0] upper_pct(input logic [DUTY_W-1:0] code);
      case (code)
         4'h0: upper_pct = 8'h07;
         4'h1: upper_pct = 8'h09;
         4'h2: upper_pct = 8'h0b;
         4'h3: upper_pct = 8'h0e;
         4'h4: upper_pct = 8'h11;
         4'h5: upper_pct = 8'h14;
         4'h6: upper_pct = 8'h17;
         4'h7: upper_pct = 8'h1a;
         4'h8: upper_pct = 8'h1e;
         4'h9: upper_pct = 8'h23;
         4'ha: upper_pct = 8'h28;
         4'hb: upper_pct = 8'h2e;
         4'hc: upper_pct = 8'h35;
         4'hd: upper_pct = 8'h3f;
         4'he: upper_pct = 8'h4d;
         default: upper_pct = 8'h64;
      endcase
   endfunction

   function automatic logic [7:0] lower_pct(input logic [DUTY_W-1:0] code);
      lower_pct = (code == 4'h0) ? 8'h00 : upper_pct(code - 4'h1);
   endfunction

endpackage

// file: rtl/ldr_timebase.sv
// Millisecond tick and free-running PWM frame counter shared by all LED channels.
// Assumes one system clock; the tick period is a parameter so simulation can shorten it.
`timescale 1ns/1ps
module ldr_timebase
#(
   parameter int TICK_CYCLES = ldr_pkg::TICK_CYCLES  // Clocks per millisecond tick
)
(
   input wire logic clk_sys,                          // System clock
   input wire logic rst,                              // Asynchronous reset, active high
   output logic msTick,                               // One-cycle pulse each millisecond
   output logic [ldr_pkg::PWM_W-1:0] pwmCount         // PWM frame position
);
   import ldr_pkg::*;

   // Whole state of the time base
   typedef struct packed {
      logic [TICK_W-1:0] tickCnt;  // Clocks within the current millisecond
      logic tick;                  // Registered tick pulse
      logic [PWM_W-1:0] pwm;       // Frame counter
   } ldr_tb_state_t;

   ldr_tb_state_t s;       // Current state
   ldr_tb_state_t next_s;  // Next state

   // Count clocks to the tick and wrap the PWM frame
   always_comb
   begin
      next_s = s;
      next_s.tick = 1'b0;
      if (s.tickCnt == TICK_W'(TICK_CYCLES - 1))
      begin
         next_s.tickCnt = '0;
         next_s.tick = 1'b1;
      end
      else
      begin
         next_s.tickCnt = s.tickCnt + 1'b1;
      end
      // Frame wraps at the last count so a full duty stays high all frame
      next_s.pwm = (s.pwm == PWM_LAST) ? '0 : s.pwm + 1'b1;
   end

   // State register
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign msTick = s.tick;
   assign pwmCount = s.pwm;

endmodule

// file: rtl/ldr_direct_led.sv
// Direct-mode LED timing: ramp registers, off delay and per-LED ramp and PWM output.
// Assumes register accesses and LED actuation come from logic on the same system clock.
`timescale 1ns/1ps
module ldr_direct_led
#(
   parameter int TICK_CYCLES = ldr_pkg::TICK_CYCLES  // Clocks per millisecond
)
(
   input wire logic clk_sys,                             // System clock
   input wire logic rst,                                 // Asynchronous reset, active high
   input wire logic [7:0] regAddr,                       // Register address
   input wire logic [7:0] regWrData,                     // Write data
   input wire logic regWrEn,                             // Write strobe, one cycle
   input wire logic regRdEn,                             // Read strobe, one cycle
   output logic [7:0] regRdData,                         // Read data, valid the cycle after regRdEn
   input wire logic [ldr_pkg::LED_COUNT-1:0] actuate,    // LED actuated, level per LED
   input wire logic [ldr_pkg::LED_COUNT-1:0] polarity,   // Output polarity bit per LED
   output logic [ldr_pkg::LED_COUNT-1:0] ledOut          // PWM drive per LED
);
   import ldr_pkg::*;

   // Whole state of the block
   // Position 0 shows the lower duty limit and RAMP_STEPS the upper one
   typedef struct packed {
      logic [7:0] directDuty;                    // Upper and lower duty codes
      logic [7:0] directRampRates;               // Rise and fall codes
      logic [7:0] directOffDelay;                // Release hold code
      logic [7:0] rdData;                        // Registered read answer
      ldr_phase_t [LED_COUNT-1:0] phase;         // Ramp phase per LED
      ldr_pos_t [LED_COUNT-1:0] pos;             // Ramp position, 0 to RAMP_STEPS
      ldr_step_t [LED_COUNT-1:0] stepCnt;        // Ms spent on the current step
      ldr_ms_t [LED_COUNT-1:0] holdCnt;          // Ms spent in the off delay
      logic [LED_COUNT-1:0] out;                 // Registered LED drive
   } ldr_state_t;

   ldr_state_t s;       // Current state
   ldr_state_t next_s;  // Next state

   logic msTick;                  // Millisecond pulse
   logic [PWM_W-1:0] pwmCount;    // PWM frame position

   // Decoded settings, shared by every LED
   ldr_step_t riseStep;           // Ms per rise step
   ldr_step_t fallStep;           // Ms per fall step
   ldr_ms_t holdTime;             // Off delay in ms
   logic [7:0] upperDuty;         // Maximum duty in percent
   logic [7:0] lowerDuty;         // Minimum duty in percent

   // Time base shared by all channels
   // One tick counter for every LED keeps their ramps in step and saves area
   ldr_timebase #(
      .TICK_CYCLES(TICK_CYCLES)
   ) timebase (
      .clk_sys(clk_sys),
      .rst(rst),
      .msTick(msTick),
      .pwmCount(pwmCount)
   );

   // Decode the live register contents; duty limits are read every cycle,
   // so a write lands on the very next PWM compare without re-actuation
   always_comb
   begin
      riseStep = step_ms(s.directRampRates[RISE_LSB +: CODE_W]);
      fallStep = step_ms(s.directRampRates[FALL_LSB +: CODE_W]);
      holdTime = hold_ms(s.directOffDelay[HOLD_LSB +: CODE_W]);
      upperDuty = upper_pct(s.directDuty[UPPER_LSB +: DUTY_W]);
      lowerDuty = lower_pct(s.directDuty[LOWER_LSB +: DUTY_W]);
   end

   // Register file, ramp sequencer and PWM compare for every LED
   always_comb
   begin
      ldr_cmp_t cmp;
      cmp = '0;
      next_s = s;

      // Register writes; unused bits are dropped so they read back as zero
      // Masking at write time means the read path never needs its own mask
      if (regWrEn)
      begin
         unique case (regAddr)
            ADDR_DUTY:
            begin
               next_s.directDuty = regWrData & DUTY_MASK;
            end
            ADDR_RAMP:
            begin
               next_s.directRampRates = regWrData & RAMP_MASK;
            end
            ADDR_DELAY:
            begin
               next_s.directOffDelay = regWrData & DELAY_MASK;
            end
            default:
            begin
               // Writes elsewhere are ignored
            end
         endcase
      end

      // Register reads; answer stands until the next read
      // A read together with a write to the same place returns the old value
      if (regRdEn)
      begin
         unique case (regAddr)
            ADDR_DUTY:
            begin
               next_s.rdData = s.directDuty;
            end
            ADDR_RAMP:
            begin
               next_s.rdData = s.directRampRates;
            end
            ADDR_DELAY:
            begin
               next_s.rdData = s.directOffDelay;
            end
            default:
            begin
               next_s.rdData = READ_IDLE;
            end
         endcase
      end

      // Per-LED sequencer; only the three timing codes steer it
      for (int i = 0; i < LED_COUNT; i++)
      begin
         unique case (s.phase[i])
            // Resting at minimum duty
            // An instant rise skips the ramp and lands on the top position;
            // the step counter restarts so a ramp never inherits a part step
            PH_LOW:
            begin
               if (actuate[i])
               begin
                  next_s.stepCnt[i] = '0;
                  if (riseStep == '0)
                  begin
                     next_s.pos[i] = RAMP_STEPS;
                     next_s.phase[i] = PH_HIGH;
                  end
                  else
                  begin
                     next_s.phase[i] = PH_RISE;
                  end
               end
            end

            // Climbing from minimum to maximum
            PH_RISE:
            begin
               if (!actuate[i])
               begin
                  // Release mid-rise holds the level reached, then falls from it
                  next_s.holdCnt[i] = '0;
                  next_s.stepCnt[i] = '0;
                  next_s.phase[i] = (holdTime == '0) ? PH_FALL : PH_HOLD;
               end
               else if (riseStep == '0)
               begin
                  next_s.pos[i] = RAMP_STEPS;  // Code changed to instant mid-ramp
                  next_s.phase[i] = PH_HIGH;
               end
               else if (s.pos[i] >= RAMP_STEPS)
               begin
                  // Already at the top; stepping on would take the position past RAMP_STEPS
                  next_s.pos[i] = RAMP_STEPS;
                  next_s.phase[i] = PH_HIGH;
               end
               else if (msTick)
               begin
                  if (s.stepCnt[i] + 1'b1 >= riseStep)
                  begin
                     next_s.stepCnt[i] = '0;
                     next_s.pos[i] = s.pos[i] + 1'b1;
                     if (s.pos[i] + 1'b1 == RAMP_STEPS)
                     begin
                        next_s.phase[i] = PH_HIGH;
                     end
                  end
                  else
                  begin
                     next_s.stepCnt[i] = s.stepCnt[i] + 1'b1;
                  end
               end
            end

            // Holding maximum while actuated
            // Duty limits are decoded live, so a duty write here shows at once
            PH_HIGH:
            begin
               if (!actuate[i])
               begin
                  next_s.holdCnt[i] = '0;
                  next_s.stepCnt[i] = '0;
                  next_s.phase[i] = (holdTime == '0) ? PH_FALL : PH_HOLD;
               end
            end

            // Off delay: stay active, then fall
            PH_HOLD:
            begin
               if (actuate[i])
               begin
                  // Re-actuation during the delay resumes the climb
                  next_s.stepCnt[i] = '0;
                  next_s.phase[i] = (s.pos[i] == RAMP_STEPS) ? PH_HIGH : PH_RISE;
               end
               // End test comes before the tick, so a code lowered mid-delay ends it at once
               else if (s.holdCnt[i] >= holdTime)
               begin
                  next_s.phase[i] = PH_FALL;
               end
               else if (msTick)
               begin
                  next_s.holdCnt[i] = s.holdCnt[i] + 1'b1;
               end
            end

            // Descending from the held level to minimum
            PH_FALL:
            begin
               if (actuate[i])
               begin
                  // Re-actuation before the first fall step is still at the top:
                  // go straight back to high instead of climbing past the last position
                  next_s.stepCnt[i] = '0;
                  next_s.phase[i] = (s.pos[i] == RAMP_STEPS) ? PH_HIGH : PH_RISE;
               end
               else if (fallStep == '0 || s.pos[i] == '0)
               begin
                  next_s.pos[i] = '0;
                  next_s.phase[i] = PH_LOW;
               end
               else if (msTick)
               begin
                  if (s.stepCnt[i] + 1'b1 >= fallStep)
                  begin
                     next_s.stepCnt[i] = '0;
                     next_s.pos[i] = s.pos[i] - 1'b1;
                  end
                  else
                  begin
                     next_s.stepCnt[i] = s.stepCnt[i] + 1'b1;
                  end
               end
            end

            default:
            begin
               next_s.phase[i] = PH_LOW;  // Unused encodings recover to rest
            end
         endcase

         // Blend the two limits by ramp position; avoids any divider
         // Worst case 100 % times 250 steps equals the frame length, one past the
         // last frame count, so a full duty never shows a low cycle
         cmp = ldr_cmp_t'(lowerDuty * (RAMP_STEPS - s.pos[i])) + ldr_cmp_t'(upperDuty * s.pos[i]);
         // Drive high for the on part of the frame, inverted when polarity is zero
         next_s.out[i] = polarity[i] ~^ ({1'b0, pwmCount} < cmp);
      end
   end

   // State register; duty limits reset to their default
   // Every LED wakes at rest, showing the lower duty limit
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         s <= '0;
         s.directDuty <= DUTY_RESET;
         s.directRampRates <= RAMP_RESET;
         s.directOffDelay <= DELAY_RESET;
         for (int i = 0; i < LED_COUNT; i++)
         begin
            s.phase[i] <= PH_LOW;
         end
      end
      else
      begin
         s <= next_s;
      end
   end

   assign regRdData = s.rdData;
   assign ledOut = s.out;

endmodule

// file: bench/ldr_direct_led_assertions.sv
// Checker for the Direct-mode LED block: register reads and steady output levels.
// Assumes it is bound to the block top and sees only its ports.
`timescale 1ns/1ps
module ldr_direct_led_assertions
#(
   parameter int TICK_CYCLES = ldr_pkg::TICK_CYCLES  // Clocks per ms tick, handed on by the bind
)
(
   input wire logic clk_sys,                            // System clock
   input wire logic rst,                                // Asynchronous reset
   input wire logic [7:0] regAddr,                      // Register address
   input wire logic [7:0] regWrData,                    // Write data
   input wire logic regWrEn,                            // Write strobe
   input wire logic regRdEn,                            // Read strobe
   input wire logic [7:0] regRdData,                    // Read answer
   input wire logic [ldr_pkg::LED_COUNT-1:0] actuate,   // Actuation levels
   input wire logic [ldr_pkg::LED_COUNT-1:0] polarity,  // Polarity bits
   input wire logic [ldr_pkg::LED_COUNT-1:0] ledOut     // PWM drive
);
   import ldr_pkg::*;
   logic [7:0] dutyMir;  // Shadow of the duty limits
   logic [7:0] rampMir;  // Shadow of the ramp codes
   logic [7:0] delayMir; // Shadow of the off-delay code
   logic [7:0] expRead;  // Answer expected for the current address

   // Shadows follow writes, so reads are predicted without looking inside
   always_ff @(posedge clk_sys or posedge rst)
   begin
      if (rst)
      begin
         dutyMir <= 8'hf0;
         rampMir <= 8'h00;
         delayMir <= 8'h00;
      end
      else if (regWrEn)
      begin
         if (regAddr == ADDR_DUTY) dutyMir <= regWrData;
         if (regAddr == ADDR_RAMP) rampMir <= regWrData & 8'h3f;
         if (regAddr == ADDR_DELAY) delayMir <= regWrData & 8'h07;
      end
   end

   // Decode of the expected read answer
   always_comb
   begin
      case (regAddr)
         ADDR_DUTY: expRead = dutyMir;
         ADDR_RAMP: expRead = rampMir;
         ADDR_DELAY: expRead = delayMir;
         default: expRead = 8'h00;  // Unmapped places read zero
      endcase
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   // LED 2 held fully on: instant rise, upper limit at full duty
   sequence fullOn;
      (actuate[2] && rampMir[5:3] == 3'h0 && dutyMir[7:4] == 4'hf && $stable(polarity[2]))[*6];
   endsequence
   // LED 2 released with a non-zero off delay
   sequence heldRelease;
      (!actuate[2] && delayMir[2:0] != 3'h0 && dutyMir[7:4] == 4'hf && $stable(polarity[2]))[*8];
   endsequence
   // LED 0 at rest with instant fall, no delay and a 0 % lower limit
   sequence restOff;
      (!actuate[0] && rampMir[2:0] == 3'h0 && delayMir == 8'h00 && dutyMir[3:0] == 4'h0
         && $stable(polarity[0]))[*8];
   endsequence

   read_hold_a: assert property (!regRdEn |=> $stable(regRdData))
      else $error("read data moved without a read");
   ramp_read_a: assert property (regRdEn && regAddr == ADDR_RAMP |=> regRdData == $past(rampMir))
      else $error("ramp register read wrong");
   delay_read_a: assert property (regRdEn && regAddr == ADDR_DELAY |=> regRdData == $past(delayMir))
      else $error("off-delay register read wrong");
   duty_read_a: assert property (regRdEn && regAddr == ADDR_DUTY |=> regRdData == $past(dutyMir))
      else $error("duty register read wrong");
   unmapped_read_a: assert property (regRdEn && expRead == 8'h00 |=> regRdData == 8'h00)
      else $error("zero read expected");
   rest_level_a: assert property (restOff |-> ledOut[0] == !polarity[0])
      else $error("resting output not at idle level");
   instant_full_a: assert property (fullOn |-> ledOut[2] == polarity[2])
      else $error("instant rise not at full drive");
   hold_active_a: assert property (fullOn ##1 heldRelease |-> ledOut[2] == polarity[2])
      else $error("output dropped during off delay");
endmodule

bind ldr_direct_led ldr_direct_led_assertions #(.TICK_CYCLES(TICK_CYCLES)) checker_inst (
   .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
   .regRdEn(regRdEn), .regRdData(regRdData), .actuate(actuate), .polarity(polarity), .ledOut(ledOut));

// file: bench/ldr_led_model.sv
// Lamp model at one PWM pin: counts the cycles the pin is driven high.
// Assumes the pin is sampled on the system clock; a restart pulse opens a window.
`timescale 1ns/1ps
module ldr_led_model
(
   input wire logic clk_sys,    // System clock
   input wire logic pin,        // PWM drive from the block
   input wire logic restart,    // Clears the count
   output logic [15:0] highCnt  // High cycles since restart
);
   // Only a clean high counts; an unknown level never lights the lamp
   always_ff @(posedge clk_sys)
   begin
      if (restart)
         highCnt <= 16'h0000;
      else if (pin === 1'b1)
         highCnt <= highCnt + 16'h0001;
   end
endmodule

// file: bench/ldr_direct_led_tb.sv
// Self-checking bench: register accesses, then PWM duty windows per LED.
// Assumes a shortened ms tick of 8 clocks; a full-frame window makes counts phase-free.
`timescale 1ns/1ps
module ldr_direct_led_tb;
   import ldr_pkg::*;
   localparam int TICKS = 8;      // Clocks per ms tick in simulation
   localparam int FRAME = 25000;  // PWM frame length in clocks
   logic clk_sys = 1'b0;          // System clock
   logic rst = 1'b1;              // Reset, held at start
   logic [7:0] regAddr = 8'h00;   // Register address
   logic [7:0] regWrData = 8'h00; // Write data
   logic regWrEn = 1'b0;          // Write strobe
   logic regRdEn = 1'b0;          // Read strobe
   logic [7:0] regRdData;         // Read answer
   logic [LED_COUNT-1:0] actuate = 4'h0;  // Actuation levels
   logic [LED_COUNT-1:0] polarity = 4'h5; // LEDs 0 and 2 non-inverted
   logic [LED_COUNT-1:0] ledOut;  // PWM drive
   logic restart = 1'b0;          // Opens a counting window
   logic [15:0] highCnt [LED_COUNT]; // High counts per lamp
   int errorCnt = 0;              // Mismatches
   int checked = 0;               // Comparisons
   int endLvl [LED_COUNT] = '{4250, 20750, 4250, 20750}; // All LEDs back at 17 %

   always #2 clk_sys = ~clk_sys;

   ldr_direct_led #(.TICK_CYCLES(TICKS)) dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
      .actuate(actuate), .polarity(polarity), .ledOut(ledOut));

   // One lamp per output pin
   for (genvar i = 0; i < LED_COUNT; i++)
   begin : g_lamp
      ldr_led_model lamp (.clk_sys(clk_sys), .pin(ledOut[i]), .restart(restart), .highCnt(highCnt[i]));
   end

   // Verdict and end of run
   task automatic conclude();
      if (errorCnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Byte comparison
   task automatic cmpByte(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // Count comparison with a tolerance for ramp quantisation
   task automatic cmpCount(input string what, input int exp, input int tol, input logic [15:0] got);
      checked++;
      if ($isunknown(got) || int'(got) < exp - tol || int'(got) > exp + tol)
      begin
         errorCnt++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask

   // One bus cycle from a falling edge; strobes stay up until the next call
   task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      regWrEn = w;
      regRdEn = r;
      regAddr = a;
      regWrData = d;
      @(negedge clk_sys);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(1'b1, 1'b0, a, d);
   endtask

   // Read; the answer is settled by the falling edge after the read edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, 1'b1, a, 8'h00);
      cmpByte("read data", exp, regRdData);
   endtask

   // Strobes down, then wait; a long wait with strobes up would repeat the access
   task automatic idle(input int n);
      acc(1'b0, 1'b0, 8'h00, 8'h00);
      repeat (n - 1) @(negedge clk_sys);
   endtask

   // Count high cycles over exactly one PWM frame in every lamp
   task automatic measure();
      restart = 1'b1;
      @(negedge clk_sys);
      restart = 1'b0;
      repeat (FRAME) @(negedge clk_sys);
   endtask

   // Main sequence
   initial
   begin
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      idle(10);
      rd(8'h93, 8'hf0);
      rd(8'h94, 8'h00);
      rd(8'h95, 8'h00);
      wr(8'h94, 8'hff);
      rd(8'h94, 8'h3f);
      wr(8'h95, 8'hff);
      rd(8'h95, 8'h07);
      wr(8'h96, 8'h5a);
      rd(8'h96, 8'h00);
      acc(1'b1, 1'b1, 8'h94, 8'h00);
      cmpByte("read data", 8'h3f, regRdData);
      rd(8'h94, 8'h00);
      // Every rise, fall and off-delay code once
      for (int c = 0; c < 8; c++)
      begin
         wr(8'h94, {2'h0, 3'(c), 3'(7 - c)});
         rd(8'h94, {2'h0, 3'(c), 3'(7 - c)});
         wr(8'h95, {5'h00, 3'(c)});
         rd(8'h95, {5'h00, 3'(c)});
      end
      // Limits 17 % and 100 %, instant ramps, LEDs 2 and 3 on
      wr(8'h93, 8'hf5);
      rd(8'h93, 8'hf5);
      wr(8'h94, 8'h00);
      wr(8'h95, 8'h00);
      actuate = 4'hc;
      idle(10);
      measure();
      cmpCount("lamp 0 rest", 4250, 0, highCnt[0]);
      cmpCount("lamp 1 rest", 20750, 0, highCnt[1]);
      cmpCount("lamp 2 on", 25000, 0, highCnt[2]);
      cmpCount("lamp 3 on", 0, 0, highCnt[3]);
      // 4 s off delay, then release with the upper limit held
      wr(8'h95, 8'h06);
      actuate = 4'h0;
      idle(10);
      // 1.5 s ramps, 48 clocks a step; release halfway at step 125
      wr(8'h94, 8'h36);
      actuate[0] = 1'b1;
      wr(8'h94, 8'h36);
      idle(5998);
      actuate[0] = 1'b0;
      idle(100);
      measure();
      cmpCount("lamp 0 held", 14625, 250, highCnt[0]);
      cmpCount("lamp 1 held", 20750, 0, highCnt[1]);
      cmpCount("lamp 2 held", 25000, 0, highCnt[2]);
      cmpCount("lamp 3 held", 0, 0, highCnt[3]);
      idle(13500);
      measure();
      for (int i = 0; i < LED_COUNT; i++)
      begin
         cmpCount("lamp after fall", endLvl[i], 0, highCnt[i]);
      end
      conclude();
   end

   // Watchdog well beyond the expected run of about 95000 cycles
   initial
   begin
      repeat (110000) @(posedge clk_sys);
      errorCnt++;
      conclude();
   end
endmodule
